/* verilog/icc_capture.sv */
// Operation
// - Eight independent channels, each with control, buffer, flags and interrupt event.
// - Patterns: falling, rising, every 4th rising, every 16th rising, both edges.
// - Three-bit mode field in control bits 2..0 picks the pattern.
// - Prescaler counter clears when channel is off and on reset.
// - Each channel buffers captures in a four-deep, 16-bit first-in first-out.
// - Not-empty flag sets on first capture, holds until all are read.
// - Each buffer read returns the oldest word and advances the rest.
// - Fifth capture on a full buffer sets overflow and is discarded.
// - After overflow, captures are ignored until all four words are read.
// - Control bit 7 picks one of two 16-bit time bases.
// - Third time base is every channel's default after reset.
// - Mode 001 captures both edges and flags an interrupt on each.
// - Mode 001 ignores the events-per-interrupt field.
// - Mode 001 never raises overflow.
// - Control bits 6..5 set how many captures occur per interrupt event.
// - Mode 111 is a rising-edge interrupt and wake source, timer state aside.
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`default_nettype none
module icc_capture #(
  parameter int unsigned NCH = icc_pkg::ICC_NUM_CH
) (
  // Clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic                           hready,
  input  wire logic [icc_pkg::ICC_HDATA_W-1:0] hwdata,
  output logic      [icc_pkg::ICC_HDATA_W-1:0] hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  // Capture pins and time bases
  input  wire logic [NCH-1:0]                 cap_pin,
  input  wire logic [icc_pkg::ICC_DATA_W-1:0] second_timebase,
  input  wire logic [icc_pkg::ICC_DATA_W-1:0] third_timebase,
  // Processor power state
  input  wire logic                           cpu_idle,
  input  wire logic                           cpu_sleep,
  // Interrupt and wake events
  output logic      [NCH-1:0]                 channel_interrupt_flag,
  output logic      [NCH-1:0]                 wake_pulse
);
  import icc_pkg::*;

  // Checks sample on the bus clock and rest during reset
  default clocking cb_chk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Channel count must fit the address decode
  if (NCH < 1 || NCH > (1 << ICC_CH_W)) begin : g_bad
    $error("icc_capture supports 1 to 8 channels");
  end

  typedef struct packed {
    logic                   wr_pend;
    logic [ICC_CH_W-1:0]    wr_ch;
    logic                   wr_con;
    logic [ICC_HDATA_W-1:0] rdata;
    logic [NCH-1:0][2:0]    mode;
    logic [NCH-1:0][1:0]    epi;
    logic [NCH-1:0]         tsel;
    logic [NCH-1:0]         sidl;
    logic [NCH-1:0]         ovf;
    logic [NCH-1:0]         blk;
    logic [NCH-1:0][1:0]    icnt;
    logic [NCH-1:0]         irq;
    logic [NCH-1:0]         wake;
  } icc_top_st_t;

  icc_top_st_t st_q;
  icc_top_st_t st_d;

  // Bus decode
  logic                acc;
  logic                in_map;
  logic                sel_con;
  logic [ICC_CH_W-1:0] ch;
  logic                rd_acc;

  // Per-channel wires
  logic [NCH-1:0]        run;
  logic [NCH-1:0]        cap;
  logic [NCH-1:0]        int_ev;
  logic [NCH-1:0]        push;
  logic [NCH-1:0]        pop;
  logic [NCH-1:0]        full;
  logic [NCH-1:0]        empty;
  logic [NCH-1:0]        ovf_set;
  logic [NCH-1:0]        wr_hit;
  logic [ICC_DATA_W-1:0] cap_val [NCH];
  logic [ICC_DATA_W-1:0] fifo_rd [NCH];
  logic [ICC_HDATA_W-1:0] con_rd [NCH];

  // ---------------------------------------------------------------
  // Address phase decode
  // ---------------------------------------------------------------
  assign acc     = hsel & hready & (htrans == ICC_HTRANS_NONSEQ) & (hsize == ICC_HSIZE_WORD);
  assign ch      = haddr[ICC_CH_LSB +: ICC_CH_W];
  assign sel_con = haddr[ICC_SEL_BIT];
  assign in_map  = (32'(haddr[ICC_ADDR_W-1:ICC_CH_LSB]) < NCH);
  assign rd_acc  = acc & ~hwrite & in_map;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = ICC_HRESP_OKAY;
  assign hrdata    = st_q.rdata;

  // Event outputs straight from flops
  assign channel_interrupt_flag = st_q.irq;
  assign wake_pulse             = st_q.wake;

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // Stop while asleep, or idle with stop-in-idle set, except mode 111
    assign run[i] = (st_q.mode[i] == ICC_MODE_INT) |
                    ~(cpu_sleep | (cpu_idle & st_q.sidl[i]));

    // Time base select, cleared bit picks the third
    assign cap_val[i] = (st_q.tsel[i] == ICC_TSEL_SECOND) ? second_timebase
                                                          : third_timebase;

    // Store when room and not locked out
    assign push[i] = cap[i] & ~st_q.blk[i] & ~full[i];

    // Overflow on a capture to a full buffer, never in both-edge mode
    assign ovf_set[i] = cap[i] & ~st_q.blk[i] & full[i] &
                        (st_q.mode[i] != ICC_MODE_BOTH);

    // Buffer read only pops when something is stored
    assign pop[i] = rd_acc & ~sel_con & (ch == ICC_CH_W'(i)) & ~empty[i];

    // Control write lands on this channel in the data phase
    assign wr_hit[i] = st_q.wr_pend & st_q.wr_con & (st_q.wr_ch == ICC_CH_W'(i));

    // Control word as read back
    always_comb begin
      con_rd[i]                            = '0;
      con_rd[i][ICC_MODE_MSB:ICC_MODE_LSB] = st_q.mode[i];
      con_rd[i][ICC_BNE_BIT]               = ~empty[i];
      con_rd[i][ICC_OVF_BIT]               = st_q.ovf[i];
      con_rd[i][ICC_EPI_MSB:ICC_EPI_LSB]   = st_q.epi[i];
      con_rd[i][ICC_TSEL_BIT]              = st_q.tsel[i];
      con_rd[i][ICC_SIDL_BIT]              = st_q.sidl[i];
    end

    icc_edge u_edge (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (cap_pin[i]),
      .mode     (st_q.mode[i]),
      .run      (run[i]),
      .capture  (cap[i]),
      .int_only (int_ev[i])
    );

    icc_fifo #(
      .WIDTH (ICC_DATA_W),
      .DEPTH (ICC_FIFO_DEPTH)
    ) u_fifo (
      .hclk    (hclk),
      .hresetn (hresetn),
      .push    (push[i]),
      .wdata   (cap_val[i]),
      .pop     (pop[i]),
      .rdata   (fifo_rd[i]),
      .full    (full[i]),
      .empty   (empty[i])
    );

    // -------------------------------------------------------------
    // Channel checks
    // -------------------------------------------------------------
    sequence s_fifth;
      cap[i] && !st_q.blk[i] && full[i] && st_q.mode[i] != ICC_MODE_BOTH;
    endsequence
    sequence s_locked;
      st_q.blk[i] && !empty[i];
    endsequence

    a_ovf_fifth_set: assert property (s_fifth |=> st_q.ovf[i] && st_q.blk[i])
      else $error("fifth capture did not raise overflow");
    a_ovf_fifth_drop: assert property (s_fifth |-> !push[i])
      else $error("fifth capture was stored");
    a_locked_ignore: assert property (s_locked |-> !push[i])
      else $error("capture stored while locked after overflow");
    a_bne_on_store: assert property (push[i] |=> !empty[i] && con_rd[i][ICC_BNE_BIT])
      else $error("not-empty flag missing after capture");
    a_both_irq_each: assert property (
      st_q.mode[i] == ICC_MODE_BOTH && cap[i] |=> st_q.irq[i])
      else $error("both-edge capture did not flag interrupt");
    a_both_no_ovf: assert property (
      st_q.mode[i] == ICC_MODE_BOTH && !st_q.ovf[i] |=> !st_q.ovf[i])
      else $error("overflow raised in both-edge mode");
    a_store_tbase: assert property (
      push[i] && empty[i] |=> fifo_rd[i] == $past(st_q.tsel[i] ? second_timebase
                                                                : third_timebase))
      else $error("stored value is not the selected time base");
    a_int_no_store: assert property (st_q.mode[i] == ICC_MODE_INT |-> !push[i])
      else $error("interrupt-only mode stored a capture");
    a_off_silent: assert property (
      st_q.mode[i] == ICC_MODE_OFF |-> !cap[i] && !int_ev[i])
      else $error("channel switched off raised an event");
    a_lock_release: assert property (st_q.blk[i] && empty[i] |=> !st_q.blk[i])
      else $error("lockout held after the buffer drained");
    a_ovf_hold: assert property (st_q.ovf[i] && !wr_hit[i] |=> st_q.ovf[i])
      else $error("overflow flag lost without a software clear");
    a_sleep_stall: assert property (
      cpu_sleep && st_q.mode[i] != ICC_MODE_INT |-> !cap[i])
      else $error("capture taken while asleep");
    a_irq_cause: assert property (st_q.irq[i] |-> $past(cap[i] || int_ev[i]))
      else $error("interrupt event without a capture");
  end

  // ---------------------------------------------------------------
  // Next state: bus and per-channel flags
  // ---------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.irq     = '0;
    st_d.wake    = '0;
    // Capture address phase; write data follows in the data phase
    st_d.wr_pend = acc & hwrite & in_map;
    st_d.wr_ch   = ch;
    st_d.wr_con  = sel_con;
    // Read data registered at the address phase, zero off the map
    if (acc && !hwrite) begin
      if (!in_map) begin
        st_d.rdata = '0;
      end else if (sel_con) begin
        st_d.rdata = con_rd[ch];
      end else begin
        st_d.rdata = ICC_HDATA_W'(fifo_rd[ch]);
      end
    end
    for (int i = 0; i < NCH; i++) begin
      // Control write in the data phase
      if (wr_hit[i]) begin
        st_d.mode[i] = hwdata[ICC_MODE_MSB:ICC_MODE_LSB];
        st_d.epi[i]  = hwdata[ICC_EPI_MSB:ICC_EPI_LSB];
        st_d.tsel[i] = hwdata[ICC_TSEL_BIT];
        st_d.sidl[i] = hwdata[ICC_SIDL_BIT];
        st_d.ovf[i]  = st_q.ovf[i] & hwdata[ICC_OVF_BIT];
      end
      // Hardware set wins over a software clear
      if (ovf_set[i]) begin
        st_d.ovf[i] = 1'b1;
      end
      // Lockout holds until the buffer is drained
      st_d.blk[i] = ovf_set[i] | (st_q.blk[i] & ~empty[i]);
      // Interrupt event generation
      if (st_q.mode[i] == ICC_MODE_OFF) begin
        st_d.icnt[i] = '0;
      end else if (st_q.mode[i] == ICC_MODE_BOTH) begin
        st_d.irq[i]  = cap[i];
        st_d.icnt[i] = '0;
      end else if (st_q.mode[i] == ICC_MODE_INT) begin
        st_d.irq[i]  = int_ev[i];
        st_d.wake[i] = int_ev[i];
      end else if (push[i]) begin
        // Every (field + 1)-th stored capture
        if (st_q.icnt[i] == st_q.epi[i]) begin
          st_d.irq[i]  = 1'b1;
          st_d.icnt[i] = '0;
        end else begin
          st_d.icnt[i] = 2'(st_q.icnt[i] + 2'h1);
        end
      end
    end
  end

  // State register; select bits clear to the third time base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Bus checks
  // ---------------------------------------------------------------
  a_read_next_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && !in_map |=> hrdata == '0)
    else $error("unmapped read did not return zero");
  a_con_readback: assert property (
    acc && !hwrite && in_map && sel_con |=> hrdata == $past(con_rd[ch]))
    else $error("control read did not return the control word");
  a_buf_readback: assert property (
    rd_acc && !sel_con |=> hrdata == ICC_HDATA_W'($past(fifo_rd[ch])))
    else $error("buffer read did not return the oldest word");
endmodule : icc_capture
`default_nettype wire

/* include/icc_pkg.sv */
`default_nettype none
package icc_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned ICC_NUM_CH     = 8;
  localparam int unsigned ICC_FIFO_DEPTH = 4;
  localparam int unsigned ICC_DATA_W     = 16;
  localparam int unsigned ICC_HDATA_W    = 32;

  // ---------------------------------------------------------------
  // Capture mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] ICC_MODE_OFF    = 3'h0;
  localparam logic [2:0] ICC_MODE_BOTH   = 3'h1;
  localparam logic [2:0] ICC_MODE_FALL   = 3'h2;
  localparam logic [2:0] ICC_MODE_RISE   = 3'h3;
  localparam logic [2:0] ICC_MODE_RISE4  = 3'h4;
  localparam logic [2:0] ICC_MODE_RISE16 = 3'h5;
  localparam logic [2:0] ICC_MODE_INT    = 3'h7;

  // Prescaler counts
  localparam logic [3:0] ICC_PRESC_RST   = 4'h0;
  localparam logic [3:0] ICC_DIV4_LAST   = 4'h3;
  localparam logic [3:0] ICC_DIV16_LAST  = 4'hF;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned ICC_MODE_LSB = 0;
  localparam int unsigned ICC_MODE_MSB = 2;
  localparam int unsigned ICC_BNE_BIT  = 3;
  localparam int unsigned ICC_OVF_BIT  = 4;
  localparam int unsigned ICC_EPI_LSB  = 5;
  localparam int unsigned ICC_EPI_MSB  = 6;
  localparam int unsigned ICC_TSEL_BIT = 7;
  localparam int unsigned ICC_SIDL_BIT = 13;
  localparam logic        ICC_TSEL_THIRD  = 1'b0;
  localparam logic        ICC_TSEL_SECOND = 1'b1;

  // ---------------------------------------------------------------
  // Address map and bus codes
  // ---------------------------------------------------------------
  localparam int unsigned ICC_ADDR_W  = 8;
  localparam int unsigned ICC_SEL_BIT = 2;
  localparam int unsigned ICC_CH_LSB  = 3;
  localparam int unsigned ICC_CH_W    = 3;
  localparam logic [1:0]  ICC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  ICC_HSIZE_WORD    = 3'h2;
  localparam logic        ICC_HRESP_OKAY    = 1'b0;
endpackage : icc_pkg
`default_nettype wire

/* verilog/icc_edge.sv */
`default_nettype none
module icc_edge (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Pin and control
  input  wire logic       pin,
  input  wire logic [2:0] mode,
  input  wire logic       run,
  // Events
  output logic            capture,
  output logic            int_only
);
  import icc_pkg::*;

  typedef struct packed {
    logic       prev;
    logic [3:0] presc;
  } icc_edge_st_t;

  icc_edge_st_t st_q;
  icc_edge_st_t st_d;
  logic         rise;
  logic         fall;
  logic         presc_mode;
  logic         presc_hit;

  // ---------------------------------------------------------------
  // Edge detection and prescaler
  // ---------------------------------------------------------------
  always_comb begin
    rise       = run & pin & ~st_q.prev;
    fall       = run & ~pin & st_q.prev;
    presc_mode = (mode == ICC_MODE_RISE4) | (mode == ICC_MODE_RISE16);
    presc_hit  = (mode == ICC_MODE_RISE4) ? (st_q.presc == ICC_DIV4_LAST)
                                          : (st_q.presc == ICC_DIV16_LAST);
    capture    = 1'b0;
    int_only   = 1'b0;
    // Pattern select
    case (mode)
      ICC_MODE_BOTH:   capture = rise | fall;
      ICC_MODE_FALL:   capture = fall;
      ICC_MODE_RISE:   capture = rise;
      ICC_MODE_RISE4,
      ICC_MODE_RISE16: capture = rise & presc_hit;
      ICC_MODE_INT:    int_only = rise;
      default:         capture = 1'b0;
    endcase
    st_d.prev  = pin;
    st_d.presc = st_q.presc;
    // Off or non-prescaled modes hold the counter clear
    if (!presc_mode) begin
      st_d.presc = ICC_PRESC_RST;
    end else if (rise) begin
      st_d.presc = presc_hit ? ICC_PRESC_RST : 4'(st_q.presc + 4'h1);
    end
  end

  // State register, cleared on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_presc_off_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == ICC_MODE_OFF |=> st_q.presc == ICC_PRESC_RST)
    else $error("prescaler not cleared while channel off");
  a_fall_only_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == ICC_MODE_FALL) && capture |-> !pin && $past(pin))
    else $error("falling mode captured without a falling edge");
endmodule : icc_edge
`default_nettype wire

/* verilog/icc_fifo.sv */
`default_nettype none
module icc_fifo #(
  parameter int unsigned WIDTH = icc_pkg::ICC_DATA_W,
  parameter int unsigned DEPTH = icc_pkg::ICC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  // Read side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rdata,
  // Status
  output logic                  full,
  output logic                  empty
);
  import icc_pkg::*;

  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("icc_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               cnt;
  } icc_fifo_st_t;

  icc_fifo_st_t st_q;
  icc_fifo_st_t st_d;
  logic         pop_ok;
  logic         push_ok;
  logic [CW-1:0] wpos;
  logic [WIDTH-1:0] mem_nx [DEPTH];

  // Accepted strobes and write slot after any shift
  assign empty   = (st_q.cnt == '0);
  assign full    = (st_q.cnt == CW'(DEPTH));
  assign pop_ok  = pop & ~empty;
  assign push_ok = push & (~full | pop_ok);
  assign wpos    = pop_ok ? CW'(st_q.cnt - 1'b1) : st_q.cnt;
  assign rdata   = st_q.mem[0];

  // ---------------------------------------------------------------
  // Per-entry shift and load; oldest word always sits in entry 0
  // ---------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic [WIDTH-1:0] shifted;
    if (i < DEPTH - 1) begin : g_mid
      assign shifted = pop_ok ? st_q.mem[i+1] : st_q.mem[i];
    end else begin : g_last
      assign shifted = st_q.mem[i];
    end
    assign mem_nx[i] = (push_ok && wpos == CW'(i)) ? wdata : shifted;
  end

  // Next state
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < DEPTH; i++) begin
      st_d.mem[i] = mem_nx[i];
    end
    st_d.cnt = CW'(st_q.cnt + CW'(push_ok) - CW'(pop_ok));
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pop_advance: assert property (@(posedge hclk) disable iff (!hresetn)
    pop_ok && st_q.cnt > CW'(1) |=> rdata == $past(st_q.mem[1]))
    else $error("read did not advance the next word");
  a_cnt_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q.cnt <= CW'(DEPTH))
    else $error("fifo count above depth");
endmodule : icc_fifo
`default_nettype wire

/* verification/icc_pin_model.sv */
`default_nettype none
// ---------------------------------------------------------------
// Sensor on the capture pins
// ---------------------------------------------------------------
module icc_pin_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Requested levels and pace
  input  wire logic [7:0] want,
  input  wire logic       slow,
  // Sensor output
  output logic      [7:0] cap_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] d1_q;
  logic [7:0] d2_q;
  // Lag of one cycle when prompt, three when slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d1_q    <= 8'h00;
      d2_q    <= 8'h00;
      cap_pin <= 8'h00;
    end else begin
      d1_q    <= want;
      d2_q    <= d1_q;
      cap_pin <= slow ? d2_q : want;
    end
  end
endmodule : icc_pin_model
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
// ---------------------------------------------------------------
// Capture unit bench
// ---------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import icc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        cpu_idle = 1'b0, cpu_sleep = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [15:0] tb2 = 16'h0, tb3 = 16'h0;
  logic [7:0]  want = 8'h00, cap_pin, irq, wake;
  logic        hready, hreadyout, hresp;
  logic [15:0] st_q [$];
  int          n_errors = 0, num_checks = 0, seed = 18;
  int          irq_n [8], wake_n [8];

  // Clock and bus ready loop
  always #12.5 hclk = ~hclk;
  assign hready = hreadyout;

  icc_capture u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cap_pin(cap_pin),
    .second_timebase(tb2), .third_timebase(tb3), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .channel_interrupt_flag(irq), .wake_pulse(wake));

  icc_pin_model u_pin (.hclk(hclk), .hresetn(hresetn), .want(want), .slow(slow),
    .cap_pin(cap_pin));

  // Pulse counters per channel
  always @(posedge hclk) begin
    for (int i = 0; i < 8; i++) begin
      if (irq[i] === 1'b1) irq_n[i]++;
      if (wake[i] === 1'b1) wake_n[i]++;
    end
  end

  task automatic clr;
    foreach (irq_n[i]) begin
      irq_n[i] = 0;
      wake_n[i] = 0;
    end
  endtask : clr

  // One single word transfer, waits on ready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= ICC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= ICC_HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, d);
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: read %h, expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_cnt(input int ch, ei, ew);
    num_checks++;
    if (irq_n[ch] != ei || wake_n[ch] != ew) begin
      n_errors++;
      $display("Error at %0t: channel %0d pulses %0d/%0d", $time, ch, irq_n[ch], wake_n[ch]);
    end
  endtask : chk_cnt

  task automatic rchk(input logic [31:0] a, e);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rchk

  // Expected control word from its fields
  function automatic logic [31:0] con(input logic [2:0] m, input logic b, o,
                                      input logic [1:0] e, input logic t);
    return {24'h0, t, e, o, b, m};
  endfunction : con

  // New level on one pin with fresh random time bases, stamp kept
  task automatic pin(input int ch, input logic lv, input logic ts);
    tb2      <= 16'($random(seed));
    tb3      <= 16'($random(seed));
    slow     <= 1'($random(seed));
    want[ch] <= lv;
    repeat (7) @(posedge hclk);
    st_q.push_back(ts ? tb2 : tb3);
  endtask : pin

  task automatic pulse(input int ch, n, input logic ts);
    repeat (n) begin
      pin(ch, 1'b1, ts);
      pin(ch, 1'b0, ts);
    end
  endtask : pulse

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    #2000000;
    n_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    clr();
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int c = 0; c < 8; c++) rchk(8 * c + 4, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    wr(32'h80, 32'hFFFF_FFFF);
    rchk(32'h80, 32'h0);
    // Fill, overflow, lock while not drained
    wr(32'h04, con(ICC_MODE_RISE, 0, 0, 0, 0));
    pulse(0, 4, 0);
    rchk(32'h04, con(ICC_MODE_RISE, 1, 0, 0, 0));
    pulse(0, 1, 0);
    rchk(32'h04, con(ICC_MODE_RISE, 1, 1, 0, 0));
    rchk(32'h00, {16'h0, st_q[0]});
    pulse(0, 1, 0);
    for (int i = 1; i < 4; i++) rchk(32'h00, {16'h0, st_q[2 * i]});
    rchk(32'h04, con(ICC_MODE_RISE, 0, 1, 0, 0));
    chk_cnt(0, 4, 0);
    wr(32'h04, con(ICC_MODE_RISE, 0, 0, 0, 0));
    st_q.delete();
    pulse(0, 1, 0);
    rchk(32'h00, {16'h0, st_q[0]});
    // Falling edges on the second time base
    wr(32'h0C, con(ICC_MODE_FALL, 0, 0, 0, 1));
    st_q.delete();
    pulse(1, 1, 1);
    rchk(32'h08, {16'h0, st_q[1]});
    rchk(32'h0C, con(ICC_MODE_FALL, 0, 0, 0, 1));
    // Prescaler cleared by switching off, then 4th and 16th edges
    wr(32'h14, con(ICC_MODE_RISE4, 0, 0, 0, 0));
    pulse(2, 2, 0);
    wr(32'h14, con(ICC_MODE_OFF, 0, 0, 0, 0));
    wr(32'h14, con(ICC_MODE_RISE4, 0, 0, 0, 0));
    st_q.delete();
    pulse(2, 4, 0);
    rchk(32'h10, {16'h0, st_q[6]});
    wr(32'h14, con(ICC_MODE_OFF, 0, 0, 0, 0));
    wr(32'h14, con(ICC_MODE_RISE16, 0, 0, 0, 0));
    st_q.delete();
    pulse(2, 16, 0);
    rchk(32'h10, {16'h0, st_q[30]});
    chk_cnt(2, 2, 0);
    // Both edges, field ignored, no overflow
    wr(32'h1C, con(ICC_MODE_BOTH, 0, 0, 3, 0));
    clr();
    st_q.delete();
    pulse(3, 2, 0);
    chk_cnt(3, 4, 0);
    pulse(3, 1, 0);
    rchk(32'h1C, con(ICC_MODE_BOTH, 1, 0, 3, 0));
    rchk(32'h18, {16'h0, st_q[0]});
    // Every events per interrupt setting
    for (int n = 0; n < 4; n++) begin
      wr(32'h24, con(ICC_MODE_OFF, 0, 0, 0, 0));
      wr(32'h24, con(ICC_MODE_RISE, 0, 0, 2'(n), 0));
      clr();
      pulse(4, 4, 0);
      chk_cnt(4, 4 / (n + 1), 0);
      repeat (4) ahb(1'b0, 32'h20, 32'h0, rd);
    end
    // Interrupt only on rising edges while asleep
    cpu_sleep <= 1'b1;
    wr(32'h2C, con(ICC_MODE_INT, 0, 0, 0, 0));
    clr();
    pulse(5, 2, 0);
    chk_cnt(5, 2, 2);
    rchk(32'h2C, con(ICC_MODE_INT, 0, 0, 0, 0));
    cpu_sleep <= 1'b0;
    // Idle with stop-in-idle clear keeps capturing
    cpu_idle <= 1'b1;
    wr(32'h34, con(ICC_MODE_RISE, 0, 0, 0, 0));
    st_q.delete();
    pulse(6, 1, 0);
    rchk(32'h30, {16'h0, st_q[0]});
    // Idle with stop-in-idle set holds the channel still
    wr(32'h34, 32'h0000_2000 | con(ICC_MODE_RISE, 0, 0, 0, 0));
    pulse(6, 1, 0);
    rchk(32'h34, 32'h0000_2000 | con(ICC_MODE_RISE, 0, 0, 0, 0));
    cpu_idle <= 1'b0;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
